// *** verilog/cafc_top.sv ***
// apb command and register front end of the maskable cam address filter
// Summary of operation
// RULE1 - comparand register keeps its value until software rewrites it
// RULE2 - mask register persists; it is stored with each newly written entry
// RULE3 - attribute register persists and is copied into an entry on write
// RULE4 - only entries with valid set take part in any comparison
// RULE5 - write-entry fills a location whose valid bit is clear
// RULE6 - software writes skip clear for entries it will later find
// RULE7 - write-entry stores comparand, mask and attributes, then sets done
// RULE8 - software waits for done before reading error or match results
// RULE9 - error is not newly raised for a write issued while error is set
// RULE10 - find compares the plain comparand, host mask register ignored
// RULE11 - found set when any valid non-skipped entry matches, else cleared
// RULE12 - multiple-match set when more than one such entry matches
// RULE13 - invalidate clears valid of the entry chosen by the last find
// RULE14 - software alternates invalidate and find until found is clear
// RULE15 - read-entry returns comparand, mask and attributes of current entry
// RULE16 - skip sets the current entry's skip bit, excluding it from finds
// RULE17 - clear-all-skip clears every skip bit; ends an invalidation pass
// RULE18 - thirty-two entries, each compared over forty-eight address bits
// RULE19 - mask zero always matches, mask one needs equal bits; all ANDed
// RULE20 - source/dest hits need valid and enable; exact adds exact bit; ORed
// RULE21 - a command write clears done; later command writes ignored while busy
// RULE22 - lowest-numbered matching non-skipped entry becomes the current entry
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cafc_top
   import cafc_pkg::*;
#(
   parameter int N = CAFC_ENTRIES,
   parameter int W = CAFC_ADDR_W
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [W-1:0] net_src_addr,
   input wire logic [W-1:0] net_dst_addr,
   output logic src_match,
   output logic src_exact,
   output logic dst_match,
   output logic dst_exact
);
   localparam int IW = $clog2(N);
   localparam int HW = W - 32;

   cafc_state_t state;
   cafc_state_t next_state;
   logic [W-1:0] comparand;
   logic [W-1:0] host_mask;
   logic [CAFC_ATTR_W-1:0] host_attr;
   logic [2:0] opcode;
   logic done;
   logic error;
   logic found;
   logic multiple_match_flag;
   logic cur_valid;
   logic [IW-1:0] cur_idx;
   logic [W-1:0] rb_data;
   logic [W-1:0] rb_mask;
   logic [CAFC_ATTR_W-1:0] rb_attr;

   wire logic [W-1:0] ent_data [N];
   wire logic [W-1:0] ent_mask [N];
   wire logic [CAFC_ATTR_W-1:0] ent_attr [N];
   wire logic [N-1:0] host_hit_vec;
   wire logic [N-1:0] src_hit_vec;
   wire logic [N-1:0] src_exact_vec;
   wire logic [N-1:0] dst_hit_vec;
   wire logic [N-1:0] dst_exact_vec;
   wire logic [N-1:0] free_vec;
   wire logic hit_any;
   wire logic hit_multi;
   wire logic [IW-1:0] hit_idx;
   wire logic free_any;
   wire logic [IW-1:0] free_idx;

   // apb decode
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable & pready;
   wire logic wr_acc = access & pwrite;
   wire logic rd_acc = access & ~pwrite;
   wire logic hit_cmp_lo = paddr == CAFC_OFS_CMP_LO;
   wire logic hit_cmp_hi = paddr == CAFC_OFS_CMP_HI;
   wire logic hit_mask_lo = paddr == CAFC_OFS_MASK_LO;
   wire logic hit_mask_hi = paddr == CAFC_OFS_MASK_HI;
   wire logic hit_attr = paddr == CAFC_OFS_ATTR;
   wire logic hit_cmd = paddr == CAFC_OFS_CMD;
   wire logic hit_status = paddr == CAFC_OFS_STATUS;
   wire logic hit_rb_cmp_lo = paddr == CAFC_OFS_RB_CMP_LO;
   wire logic hit_rb_cmp_hi = paddr == CAFC_OFS_RB_CMP_HI;
   wire logic hit_rb_mask_lo = paddr == CAFC_OFS_RB_MASK_LO;
   wire logic hit_rb_mask_hi = paddr == CAFC_OFS_RB_MASK_HI;
   wire logic hit_rb_attr = paddr == CAFC_OFS_RB_ATTR;
   wire logic mapped = hit_cmp_lo | hit_cmp_hi | hit_mask_lo | hit_mask_hi | hit_attr | hit_cmd |
      hit_status | hit_rb_cmp_lo | hit_rb_cmp_hi | hit_rb_mask_lo | hit_rb_mask_hi | hit_rb_attr;

   wire logic busy = state == CAFC_ST_EXEC;
   // RULE21 busy blocks commands
   wire logic cmd_start = wr_acc & hit_cmd & ~busy;
   wire logic status_rd = rd_acc & hit_status;

   wire logic [31:0] status_word = {27'h0, busy, multiple_match_flag, found, error, done};
   wire logic [31:0] rd_word =
      hit_cmp_lo ? comparand[31:0] :
      hit_cmp_hi ? {16'h0000, comparand[W-1:32]} :
      hit_mask_lo ? host_mask[31:0] :
      hit_mask_hi ? {16'h0000, host_mask[W-1:32]} :
      hit_attr ? {26'h0, host_attr} :
      hit_cmd ? {29'h0, opcode} :
      hit_status ? status_word :
      hit_rb_cmp_lo ? rb_data[31:0] :
      hit_rb_cmp_hi ? {16'h0000, rb_data[W-1:32]} :
      hit_rb_mask_lo ? rb_mask[31:0] :
      hit_rb_mask_hi ? {16'h0000, rb_mask[W-1:32]} :
      hit_rb_attr ? {26'h0, rb_attr} : CAFC_RST_WORD;

   // command strobes, live only in the execute cycle
   wire logic exec = busy;
   wire logic op_write = exec & (opcode == CAFC_CMD_WRITE);
   wire logic op_find = exec & (opcode == CAFC_CMD_FIND);
   wire logic op_read = exec & (opcode == CAFC_CMD_READ);
   wire logic op_inval = exec & (opcode == CAFC_CMD_INVAL);
   wire logic op_skip = exec & (opcode == CAFC_CMD_SKIP);
   wire logic op_clr = exec & (opcode == CAFC_CMD_CLR_SKIP);
   wire logic op_bad = exec & ~(op_write | op_find | op_read | op_inval | op_skip | op_clr);
   wire logic needs_cur = op_read | op_inval | op_skip;
   // RULE9 no fresh write error while set
   wire logic raise_error = (op_write & ~free_any & ~error) | (needs_cur & ~cur_valid) | op_bad;

   // RULE18 entry array
   generate
      for (genvar i = 0; i < N; i++)
      begin : g_ent
         cafc_entry #(.W(W)) u_ent (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            // RULE5 fill a free slot
            .wr_en(op_write & free_any & (free_idx == IW'(i))),
            .wr_data(comparand),
            .wr_mask(host_mask),
            .wr_attr(host_attr),
            // RULE13 drop current entry
            .inval(op_inval & cur_valid & (cur_idx == IW'(i))),
            // RULE16 skip current entry
            .set_skip(op_skip & cur_valid & (cur_idx == IW'(i))),
            // RULE17 clear every skip
            .clr_skip(op_clr),
            .host_cmp(comparand),
            .src_addr(net_src_addr),
            .dst_addr(net_dst_addr),
            .data(ent_data[i]),
            .mask(ent_mask[i]),
            .attr(ent_attr[i]),
            .host_hit(host_hit_vec[i]),
            .src_hit(src_hit_vec[i]),
            .src_exact(src_exact_vec[i]),
            .dst_hit(dst_hit_vec[i]),
            .dst_exact(dst_exact_vec[i])
         );
         assign free_vec[i] = ~ent_attr[i][CAFC_ATTR_VALID];
      end
   endgenerate

   // RULE22 lowest match wins
   cafc_prio #(.N(N), .IW(IW)) u_hit_prio (
      .req(host_hit_vec),
      .any(hit_any),
      .multi(hit_multi),
      .idx(hit_idx)
   );

   cafc_prio #(.N(N), .IW(IW)) u_free_prio (
      .req(free_vec),
      .any(free_any),
      .multi(),
      .idx(free_idx)
   );

   always_comb
   begin
      next_state = state;
      case (state)
         CAFC_ST_IDLE:
         begin
            if (cmd_start)
               next_state = CAFC_ST_EXEC;
         end
         CAFC_ST_EXEC:
            next_state = CAFC_ST_IDLE;
         default:
            next_state = CAFC_ST_IDLE;
      endcase
   end

   // apb slave, zero wait: pready rises with penable
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pready <= 1'b0;
         prdata <= CAFC_RST_WORD;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         if (setup)
         begin
            prdata <= pwrite ? CAFC_RST_WORD : rd_word;
            pslverr <= ~mapped;
         end
      end
   end

   // RULE1 comparand held
   // RULE2 mask held
   // RULE3 attributes held
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         comparand <= CAFC_RST_ADDR;
         host_mask <= CAFC_RST_ADDR;
         host_attr <= CAFC_RST_ATTR;
      end
      else if (wr_acc)
      begin
         if (hit_cmp_lo)
            comparand[31:0] <= pwdata;
         if (hit_cmp_hi)
            comparand[W-1:32] <= pwdata[HW-1:0];
         if (hit_mask_lo)
            host_mask[31:0] <= pwdata;
         if (hit_mask_hi)
            host_mask[W-1:32] <= pwdata[HW-1:0];
         if (hit_attr)
            host_attr <= pwdata[CAFC_ATTR_W-1:0];
      end
   end

   // RULE7 command sequencing
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state <= CAFC_ST_IDLE;
         opcode <= 3'h0;
         done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (cmd_start)
         begin
            opcode <= pwdata[2:0];
            // RULE21 done cleared on issue
            done <= 1'b0;
         end
         else if (exec)
            done <= 1'b1;
      end
   end

   // error is sticky; a status read clears it, a new error in that cycle wins
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         error <= 1'b0;
      else if (raise_error)
         error <= 1'b1;
      else if (status_rd)
         error <= 1'b0;
   end

   // RULE10 plain comparand find
   // RULE11 found result
   // RULE12 multiple result
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         found <= 1'b0;
         multiple_match_flag <= 1'b0;
         cur_valid <= 1'b0;
         cur_idx <= '0;
      end
      else if (op_find)
      begin
         found <= hit_any;
         multiple_match_flag <= hit_multi;
         cur_valid <= hit_any;
         cur_idx <= hit_idx;
      end
      else if ((op_inval | op_skip) & cur_valid)
         cur_valid <= 1'b0;
   end

   // RULE15 read back current entry
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rb_data <= CAFC_RST_ADDR;
         rb_mask <= CAFC_RST_ADDR;
         rb_attr <= CAFC_RST_ATTR;
      end
      else if (op_read & cur_valid)
      begin
         rb_data <= ent_data[cur_idx];
         rb_mask <= ent_mask[cur_idx];
         rb_attr <= ent_attr[cur_idx];
      end
   end

   // RULE20 ORed network outputs
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         src_match <= 1'b0;
         src_exact <= 1'b0;
         dst_match <= 1'b0;
         dst_exact <= 1'b0;
      end
      else
      begin
         src_match <= |src_hit_vec;
         src_exact <= |src_exact_vec;
         dst_match <= |dst_hit_vec;
         dst_exact <= |dst_exact_vec;
      end
   end
endmodule : cafc_top
`default_nettype wire

// *** pkg/cafc_pkg.sv ***
// shared constants for the cam address filter command front end
package cafc_pkg;
   localparam int CAFC_ENTRIES = 32;
   localparam int CAFC_ADDR_W = 48;
   localparam int CAFC_ATTR_W = 6;
   // register byte offsets
   localparam logic [7:0] CAFC_OFS_CMP_LO = 8'h00;
   localparam logic [7:0] CAFC_OFS_CMP_HI = 8'h04;
   localparam logic [7:0] CAFC_OFS_MASK_LO = 8'h08;
   localparam logic [7:0] CAFC_OFS_MASK_HI = 8'h0c;
   localparam logic [7:0] CAFC_OFS_ATTR = 8'h10;
   localparam logic [7:0] CAFC_OFS_CMD = 8'h14;
   localparam logic [7:0] CAFC_OFS_STATUS = 8'h18;
   localparam logic [7:0] CAFC_OFS_RB_CMP_LO = 8'h1c;
   localparam logic [7:0] CAFC_OFS_RB_CMP_HI = 8'h20;
   localparam logic [7:0] CAFC_OFS_RB_MASK_LO = 8'h24;
   localparam logic [7:0] CAFC_OFS_RB_MASK_HI = 8'h28;
   localparam logic [7:0] CAFC_OFS_RB_ATTR = 8'h2c;
   // attribute field positions
   localparam int CAFC_ATTR_SRC_MATCH = 0;
   localparam int CAFC_ATTR_SRC_EXACT = 1;
   localparam int CAFC_ATTR_DST_MATCH = 2;
   localparam int CAFC_ATTR_DST_EXACT = 3;
   localparam int CAFC_ATTR_VALID = 4;
   localparam int CAFC_ATTR_SKIP = 5;
   // status field positions
   localparam int CAFC_ST_DONE = 0;
   localparam int CAFC_ST_ERROR = 1;
   localparam int CAFC_ST_FOUND = 2;
   localparam int CAFC_ST_MULTIPLE_MATCH_FLAG = 3;
   localparam int CAFC_ST_BUSY = 4;
   // reset values
   localparam logic [CAFC_ADDR_W-1:0] CAFC_RST_ADDR = 48'h0000_0000_0000;
   localparam logic [CAFC_ATTR_W-1:0] CAFC_RST_ATTR = 6'h00;
   localparam logic [31:0] CAFC_RST_WORD = 32'h0000_0000;
   // command codes
   localparam logic [2:0] CAFC_CMD_WRITE = 3'h1;
   localparam logic [2:0] CAFC_CMD_FIND = 3'h2;
   localparam logic [2:0] CAFC_CMD_READ = 3'h3;
   localparam logic [2:0] CAFC_CMD_INVAL = 3'h4;
   localparam logic [2:0] CAFC_CMD_SKIP = 3'h5;
   localparam logic [2:0] CAFC_CMD_CLR_SKIP = 3'h6;
   typedef enum logic [0:0] {
      CAFC_ST_IDLE = 1'b0,
      CAFC_ST_EXEC = 1'b1
   } cafc_state_t;
endpackage : cafc_pkg

// *** verilog/cafc_entry.sv ***
// one cam entry: stored address, mask, attributes and its compare lines
`timescale 1ns/100ps
`default_nettype none
module cafc_entry
   import cafc_pkg::*;
#(
   parameter int W = CAFC_ADDR_W
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   input wire logic [W-1:0] wr_mask,
   input wire logic [CAFC_ATTR_W-1:0] wr_attr,
   input wire logic inval,
   input wire logic set_skip,
   input wire logic clr_skip,
   input wire logic [W-1:0] host_cmp,
   input wire logic [W-1:0] src_addr,
   input wire logic [W-1:0] dst_addr,
   output logic [W-1:0] data,
   output logic [W-1:0] mask,
   output logic [CAFC_ATTR_W-1:0] attr,
   output logic host_hit,
   output logic src_hit,
   output logic src_exact,
   output logic dst_hit,
   output logic dst_exact
);
   wire logic host_eq;
   wire logic src_eq;
   wire logic dst_eq;
   wire logic valid;

   // RULE19 masked bitwise compare
   assign host_eq = &(~mask | ~(data ^ host_cmp));
   assign src_eq = &(~mask | ~(data ^ src_addr));
   assign dst_eq = &(~mask | ~(data ^ dst_addr));
   assign valid = attr[CAFC_ATTR_VALID];

   // RULE4 valid gates comparisons
   assign host_hit = valid & ~attr[CAFC_ATTR_SKIP] & host_eq;
   // RULE20 source/dest qualifiers
   assign src_hit = valid & attr[CAFC_ATTR_SRC_MATCH] & src_eq;
   assign src_exact = src_hit & attr[CAFC_ATTR_SRC_EXACT];
   assign dst_hit = valid & attr[CAFC_ATTR_DST_MATCH] & dst_eq;
   assign dst_exact = dst_hit & attr[CAFC_ATTR_DST_EXACT];

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         data <= CAFC_RST_ADDR;
         mask <= CAFC_RST_ADDR;
         attr <= CAFC_RST_ATTR;
      end
      else if (wr_en)
      begin
         data <= wr_data;
         mask <= wr_mask;
         attr <= wr_attr;
      end
      else
      begin
         if (inval)
            attr[CAFC_ATTR_VALID] <= 1'b0;
         if (set_skip)
            attr[CAFC_ATTR_SKIP] <= 1'b1;
         else if (clr_skip)
            attr[CAFC_ATTR_SKIP] <= 1'b0;
      end
   end
endmodule : cafc_entry
`default_nettype wire

// *** verilog/cafc_prio.sv ***
// lowest-index priority encoder with any and more-than-one flags
`timescale 1ns/100ps
`default_nettype none
module cafc_prio #(
   parameter int N = 32,
   parameter int IW = $clog2(N)
)(
   input wire logic [N-1:0] req,
   output logic any,
   output logic multi,
   output logic [IW-1:0] idx
);
   wire logic [N-1:0] req_dec;

   assign any = |req;
   // clearing the lowest set bit leaves something only if two were set
   assign req_dec = req - N'(1);
   assign multi = |(req & req_dec);

   always_comb
   begin
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
            idx = IW'(i);
      end
   end
endmodule : cafc_prio
`default_nettype wire

// *** verif/cafc_top_properties.sv ***
// port level checks for the cam filter command front end
`timescale 1ns/100ps
`default_nettype none
module cafc_top_properties #(
   parameter int N = 32,
   parameter int W = 48
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [W-1:0] net_src_addr,
   input wire logic [W-1:0] net_dst_addr,
   input wire logic src_match,
   input wire logic src_exact,
   input wire logic dst_match,
   input wire logic dst_exact
);
   wire logic setup = psel && !penable;
   wire logic unmapped = paddr > 8'h2c || paddr[1:0] != 2'h0;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   rst_quiet_a: assert property ($fell(sys_rst) |-> !src_match && !dst_match && !pready)
      else $error("match or ready high just after reset");
   src_exact_a: assert property (src_exact |-> src_match)
      else $error("source exact without source match");
   dst_exact_a: assert property (dst_exact |-> dst_match)
      else $error("dest exact without dest match");
   ready_pulse_a: assert property (setup |=> pready)
      else $error("no ready after setup");
   ready_once_a: assert property (pready |-> $past(setup) ##1 !pready)
      else $error("ready not a single pulse after setup");
   err_map_a: assert property (setup |=> pslverr == $past(unmapped))
      else $error("slave error does not follow the address map");
   rdata_hold_a: assert property (!setup |=> $stable(prdata))
      else $error("read data moved outside a setup edge");
   net_settle_a: assert property ((!psel && $stable(net_src_addr) && $stable(net_dst_addr)) [*3]
      |=> $stable({src_match, src_exact, dst_match, dst_exact}))
      else $error("match lines moved with quiet inputs");
   cover property (src_match && src_exact);
   cover property (pready && pslverr);
   cover property (dst_match && !dst_exact);
endmodule : cafc_top_properties
bind cafc_top cafc_top_properties #(.N(N), .W(W)) u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .net_src_addr(net_src_addr), .net_dst_addr(net_dst_addr),
   .src_match(src_match), .src_exact(src_exact), .dst_match(dst_match), .dst_exact(dst_exact));
`default_nettype wire

// *** verif/cafc_host.sv ***
// host processor model on the apb register port
`timescale 1ns/100ps
`default_nettype none
module cafc_host
   import cafc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output var logic psel,
   output var logic penable,
   output var logic pwrite,
   output var logic [7:0] paddr,
   output var logic [31:0] pwdata,
   output var logic tmo
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tmo = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
         tmo <= 1'b1;
   endtask : xfer
   task automatic cmd(input logic [2:0] op, output logic [31:0] st);
      logic er;
      int n;
      xfer(1'b1, CAFC_OFS_CMD, {29'h0, op}, st, er);
      n = 0;
      do
      begin
         xfer(1'b0, CAFC_OFS_STATUS, 32'h0, st, er);
         n++;
      end
      while (st[CAFC_ST_DONE] !== 1'b1 && n < 16);
      if (st[CAFC_ST_DONE] !== 1'b1)
         tmo <= 1'b1;
   endtask : cmd
endmodule : cafc_host
`default_nettype wire

// *** verif/tb.sv ***
// command sequence testbench for the cam filter front end
`timescale 1ns/100ps
`default_nettype none
module tb
   import cafc_pkg::*;
;
   localparam logic [47:0] A = 48'h5a5a_0102_0304;
   // skip clear in every attribute value, valid set where it should match
   localparam logic [31:0] AT = 32'h17;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [47:0] net_src_addr = 48'h0;
   logic [47:0] net_dst_addr = 48'h0;
   wire logic psel, penable, pwrite, pready, pslverr, tmo;
   wire logic src_match, src_exact, dst_match, dst_exact;
   wire logic [7:0] paddr;
   wire logic [31:0] pwdata, prdata;
   int fail_count = 0;
   int cmp_count = 0;
   logic [31:0] q;
   logic e;
   cafc_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .net_src_addr(net_src_addr), .net_dst_addr(net_dst_addr), .src_match(src_match),
      .src_exact(src_exact), .dst_match(dst_match), .dst_exact(dst_exact));
   cafc_host H (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tmo(tmo));
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk)
      if (tmo === 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      H.xfer(1'b0, a, 32'h0, q, e);
      chk(nm, q, exp);
   endtask : rchk
   task automatic ld(input logic [47:0] v, input logic [7:0] lo);
      H.xfer(1'b1, lo, v[31:0], q, e);
      H.xfer(1'b1, lo + 8'h04, {16'h0, v[47:32]}, q, e);
   endtask : ld
   task automatic do_cmd(input logic [2:0] op, input logic er);
      H.cmd(op, q);
      chk("cmd status", q & 32'h13, {30'h0, er, 1'b1});
   endtask : do_cmd
   task automatic fnd(input logic [47:0] v, input logic f, input logic m);
      ld(v, CAFC_OFS_CMP_LO);
      H.cmd(CAFC_CMD_FIND, q);
      chk("find status", q & 32'h1f, {28'h0, m, f, 2'b01});
   endtask : fnd
   task automatic netc(input logic [3:0] exp);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("net lines", {28'h0, src_match, src_exact, dst_match, dst_exact}, {28'h0, exp});
      // back on a rising edge so the next stimulus is not launched mid-cycle
      @(posedge ref_clk);
   endtask : netc
   initial
   begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rchk("status reset", CAFC_OFS_STATUS, 32'h0);
      rchk("cmp reset", CAFC_OFS_CMP_LO, 32'h0);
      ld(A, CAFC_OFS_CMP_LO);
      ld(48'hffff_ffff_ffff, CAFC_OFS_MASK_LO);
      H.xfer(1'b1, CAFC_OFS_ATTR, AT, q, e);
      rchk("cmp hi", CAFC_OFS_CMP_HI, {16'h0, A[47:32]});
      rchk("mask hi", CAFC_OFS_MASK_HI, 32'h0000_ffff);
      rchk("attr", CAFC_OFS_ATTR, AT);
      H.xfer(1'b0, 8'h30, 32'h0, q, e);
      chk("unmapped", {q[30:0], e}, 32'h1);
      $display("registers done");
      do_cmd(CAFC_CMD_WRITE, 1'b0);
      net_src_addr <= A;
      net_dst_addr <= A ^ 48'h1;
      netc(4'hc);
      net_dst_addr <= A;
      netc(4'he);
      $display("network done");
      H.xfer(1'b1, CAFC_OFS_ATTR, 32'h1b, q, e);
      do_cmd(CAFC_CMD_WRITE, 1'b0);
      fnd(A, 1'b1, 1'b1);
      do_cmd(CAFC_CMD_READ, 1'b0);
      rchk("rb attr", CAFC_OFS_RB_ATTR, AT);
      rchk("rb cmp", CAFC_OFS_RB_CMP_LO, A[31:0]);
      rchk("rb cmp hi", CAFC_OFS_RB_CMP_HI, {16'h0, A[47:32]});
      rchk("rb mask", CAFC_OFS_RB_MASK_HI, 32'h0000_ffff);
      do_cmd(CAFC_CMD_SKIP, 1'b0);
      fnd(A, 1'b1, 1'b0);
      do_cmd(CAFC_CMD_INVAL, 1'b0);
      fnd(A, 1'b0, 1'b0);
      do_cmd(CAFC_CMD_CLR_SKIP, 1'b0);
      fnd(A, 1'b1, 1'b0);
      do_cmd(CAFC_CMD_INVAL, 1'b0);
      fnd(A, 1'b0, 1'b0);
      H.xfer(1'b1, CAFC_OFS_ATTR, 32'h07, q, e);
      do_cmd(CAFC_CMD_WRITE, 1'b0);
      fnd(A, 1'b0, 1'b0);
      netc(4'h0);
      $display("find and invalidate done");
      ld(48'hffff_ffff_00ff, CAFC_OFS_MASK_LO);
      H.xfer(1'b1, CAFC_OFS_ATTR, 32'h11, q, e);
      do_cmd(CAFC_CMD_WRITE, 1'b0);
      ld(48'h0, CAFC_OFS_MASK_LO);
      fnd(A ^ 48'h0000_0000_ff00, 1'b1, 1'b0);
      fnd(A ^ 48'h1, 1'b0, 1'b0);
      $display("mask done");
      repeat (31) do_cmd(CAFC_CMD_WRITE, 1'b0);
      do_cmd(CAFC_CMD_WRITE, 1'b1);
      do_cmd(3'h0, 1'b1);
      do_cmd(3'h7, 1'b1);
      H.xfer(1'b1, CAFC_OFS_CMD, 32'h7, q, e);
      repeat (2) @(posedge ref_clk);
      do_cmd(CAFC_CMD_WRITE, 1'b1);
      rchk("status after read", CAFC_OFS_STATUS, 32'h1);
      $display("errors done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
